// *** rtl/pfh_consts.vh ***
/*
 * Constants of the prefetch hint unit: hint encodings, cache attribute
 * codes, segment decode, request kinds and field positions.
 * Assumes inclusion by bare name from files under rtl/.
 */
`ifndef PFH_CONSTS_VH
`define PFH_CONSTS_VH

`define PFH_HINT_W          5
`define PFH_HINT_LOAD       5'h00
`define PFH_HINT_STORE      5'h01
`define PFH_HINT_LD_STREAM  5'h04
`define PFH_HINT_ST_STREAM  5'h05
`define PFH_HINT_LD_RETAIN  5'h06
`define PFH_HINT_ST_RETAIN  5'h07
`define PFH_HINT_WB_INVAL   5'h19
`define PFH_HINT_PREP_STORE 5'h1F

`define PFH_ATTR_W          3
`define PFH_ATTR_UNCACHED   3'h2
`define PFH_ATTR_UNC_ACCEL  3'h7
`define PFH_ATTR_COH_EXCL   3'h4
`define PFH_ATTR_COH_WRITE  3'h5

`define PFH_SEG_HI          31
`define PFH_SEG_LO          29
`define PFH_SEG_UNCACHED    3'h5

`define PFH_OFS_W           16
`define PFH_OFS_SIGN        15

`define PFH_KIND_W          3
`define PFH_KIND_LOAD       3'h0
`define PFH_KIND_STORE      3'h1
`define PFH_KIND_WB_INVAL   3'h2
`define PFH_KIND_PREP_STORE 3'h3

`define PFH_PLACE_W         2
`define PFH_PLACE_NORMAL    2'h0
`define PFH_PLACE_STREAM    2'h1
`define PFH_PLACE_RETAIN    2'h2

`define PFH_ADDR_W          32

`endif

// *** rtl/pfh_addr_gen.v ***
/*
 * Effective address generator: base register plus sign-extended offset,
 * registered. Assumes base and offset are stable while valid_in is high.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pfh_consts.vh"

module pfh_addr_gen #(
   parameter AW = `PFH_ADDR_W
) (
   input  wire                   clk,
   input  wire                   rst_n,
   input  wire                   valid_in,
   input  wire [AW-1:0]          base_in,
   input  wire [`PFH_OFS_W-1:0]  offset_in,
   output reg                    valid_q,
   output reg  [AW-1:0]          eaddr_q
);

   wire [AW-1:0] ofs_ext;

   assign ofs_ext = {{(AW-`PFH_OFS_W){offset_in[`PFH_OFS_SIGN]}}, offset_in}; // see [RL1]

   always @(posedge clk) begin
      if (!rst_n) begin
         valid_q <= 1'b0;
         eaddr_q <= {AW{1'b0}};
      end else begin
         valid_q <= valid_in;
         if (valid_in) begin
            eaddr_q <= base_in + ofs_ext; // see [RL1]
         end
      end
   end

endmodule
`default_nettype wire

// *** rtl/pfh_hint_decode.v ***
/*
 * Hint field decoder: maps the 5-bit hint to a request kind and a cache
 * placement class. Purely combinational; the caller registers results.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pfh_consts.vh"

module pfh_hint_decode (
   input  wire [`PFH_HINT_W-1:0]  hint,
   input  wire                    prep_store_en,
   output reg                     act,
   output reg  [`PFH_KIND_W-1:0]  kind,
   output reg  [`PFH_PLACE_W-1:0] place
);

   always @* begin
      act   = 1'b1;
      kind  = `PFH_KIND_LOAD;
      place = `PFH_PLACE_NORMAL;
      case (hint)
         `PFH_HINT_LOAD: begin // see [RL12]
            kind = `PFH_KIND_LOAD;
         end
         `PFH_HINT_STORE: begin // see [RL12]
            kind = `PFH_KIND_STORE;
         end
         `PFH_HINT_LD_STREAM: begin // see [RL13]
            place = `PFH_PLACE_STREAM;
         end
         `PFH_HINT_ST_STREAM: begin // see [RL13]
            kind  = `PFH_KIND_STORE;
            place = `PFH_PLACE_STREAM;
         end
         `PFH_HINT_LD_RETAIN: begin // see [RL13]
            place = `PFH_PLACE_RETAIN;
         end
         `PFH_HINT_ST_RETAIN: begin // see [RL13]
            kind  = `PFH_KIND_STORE;
            place = `PFH_PLACE_RETAIN;
         end
         `PFH_HINT_WB_INVAL: begin // see [RL14]
            kind = `PFH_KIND_WB_INVAL;
         end
         `PFH_HINT_PREP_STORE: begin // see [RL3]
            kind = `PFH_KIND_PREP_STORE;
            act  = prep_store_en;
         end
         default: begin
            // Reserved and unused implementation values do nothing.
            act = 1'b0; // see [RL15] see [RL16]
         end
      endcase
   end

endmodule
`default_nettype wire

// *** rtl/pfh_prefetch_unit.v ***
/*
 * Prefetch hint unit top. Takes a prefetch from the pipeline, forms the
 * effective address, looks up its attributes and, where useful, issues
 * one request to the cache. The pipeline never stalls on a prefetch.
 * Assumes the translation port answers combinationally in the cycle the
 * address is presented, and the cache holds cache_ready low when busy.
 */
// Overview of operation
// [RL1] Address is base plus sign-extended offset.
// [RL2] Any action must keep program meaning.
// [RL3] Only prepare-for-store may change visible state.
// [RL4] Faulting addresses dropped silently, no exceptions.
// [RL5] Invisible actions like writebacks are allowed.
// [RL6] Bus/cache error reporting is implementation choice.
// [RL7] Uncached addresses: no memory operation.
// [RL8] Use the address's own type and attribute.
// [RL9] Fetch a block containing the address.
// [RL10] Coherent attribute gives coherent transaction.
// [RL11] Obey memory barrier ordering and completion.
// [RL12] Hint 0 load fetch, hint 1 store.
// [RL13] Streamed never displaces retained data.
// [RL14] Hint 25 writeback-invalidate, locked lines untouched.
// [RL15] Reserved hints get no meaning.
// [RL16] Unimplemented hints complete as no-operation.
`timescale 1ns/1ps
`default_nettype none
`include "pfh_consts.vh"

module pfh_prefetch_unit #(
   parameter AW         = `PFH_ADDR_W,
   parameter BLOCK_BITS = 5,
   parameter PREP_STORE = 0,
   parameter ERR_REPORT = 0
) (
   input  wire                   clk,
   input  wire                   rst_n,
   input  wire                   cache_warm_hint_op,
   input  wire [`PFH_HINT_W-1:0] hint,
   input  wire [AW-1:0]          int_register_file,
   input  wire [`PFH_OFS_W-1:0]  offset,
   output reg                    tlb_req_q,
   output reg  [AW-1:0]          tlb_vaddr_q,
   input  wire                   tlb_fault,
   input  wire [`PFH_ATTR_W-1:0] cache_coherence_attribute,
   input  wire                   cache_ready,
   input  wire                   cache_done,
   input  wire                   cache_err,
   input  wire                   barrier_req,
   output reg                    barrier_ack_q,
   output reg                    cache_req_q,
   output reg  [AW-1:0]          cache_addr_q,
   output reg  [`PFH_KIND_W-1:0] cache_kind_q,
   output reg  [`PFH_PLACE_W-1:0] cache_place_q,
   output reg  [`PFH_ATTR_W-1:0] cache_attr_q,
   output reg                    cache_coherent_q,
   output reg                    done_q,
   output reg                    dropped_q,
   output reg                    err_report_q
);

   ////////////////////////////////////////////////////////////////////////
   // Address and hint front end.

   localparam [3:0] ST_IDLE  = 4'h1;
   localparam [3:0] ST_LOOK  = 4'h2;
   localparam [3:0] ST_ISSUE = 4'h4;
   localparam [3:0] ST_WAIT  = 4'h8;

   wire                    ea_valid;
   wire [AW-1:0]           ea;
   wire                    dec_act;
   wire [`PFH_KIND_W-1:0]  dec_kind;
   wire [`PFH_PLACE_W-1:0] dec_place;
   wire                    prep_en;

   reg  [3:0]              state_q;
   reg  [3:0]              state_d;
   reg  [`PFH_HINT_W-1:0]  hint_q;
   reg                     hint_hold_q;
   reg                     op_act_q;
   reg  [`PFH_KIND_W-1:0]  op_kind_q;
   reg  [`PFH_PLACE_W-1:0] op_place_q;

   assign prep_en = (PREP_STORE != 0);

   pfh_addr_gen #(
      .AW(AW)
   ) u_addr (
      .clk       (clk),
      .rst_n     (rst_n),
      .valid_in  (cache_warm_hint_op && !hint_hold_q),
      .base_in   (int_register_file),
      .offset_in (offset),
      .valid_q   (ea_valid),
      .eaddr_q   (ea)
   );

   pfh_hint_decode u_dec (
      .hint          (hint_q),
      .prep_store_en (prep_en),
      .act           (dec_act),
      .kind          (dec_kind),
      .place         (dec_place)
   );

   // Uncached by segment, or by the attribute from translation.
   function is_uncached;
      input [AW-1:0]          a;
      input [`PFH_ATTR_W-1:0] attr;
      begin
         is_uncached = (a[`PFH_SEG_HI:`PFH_SEG_LO] == `PFH_SEG_UNCACHED) ||
                       (attr == `PFH_ATTR_UNCACHED) ||
                       (attr == `PFH_ATTR_UNC_ACCEL);
      end
   endfunction

   function is_coherent;
      input [`PFH_ATTR_W-1:0] attr;
      begin
         is_coherent = (attr == `PFH_ATTR_COH_EXCL) || (attr == `PFH_ATTR_COH_WRITE);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Sequencer. A prefetch arriving while one is in flight is taken as a
   // no-operation; the trade is a lost hint against never stalling.

   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (ea_valid) begin
               state_d = ST_LOOK;
            end
         end
         ST_LOOK: begin
            if (!tlb_fault && !is_uncached(tlb_vaddr_q, cache_coherence_attribute) &&
                op_act_q && !barrier_req) begin
               state_d = ST_ISSUE;
            end else begin
               state_d = ST_IDLE;
            end
         end
         ST_ISSUE: begin
            if (cache_ready) begin
               state_d = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (cache_done) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         state_q     <= ST_IDLE;
         hint_q      <= `PFH_HINT_LOAD;
         hint_hold_q <= 1'b0;
         op_act_q    <= 1'b0;
         op_kind_q   <= `PFH_KIND_LOAD;
         op_place_q  <= `PFH_PLACE_NORMAL;
         tlb_req_q   <= 1'b0;
         tlb_vaddr_q <= {AW{1'b0}};
      end else begin
         state_q   <= state_d;
         tlb_req_q <= 1'b0;
         if (cache_warm_hint_op && !hint_hold_q) begin
            hint_q      <= hint;
            hint_hold_q <= 1'b1;
         end else if (state_q == ST_IDLE && !ea_valid) begin
            hint_hold_q <= 1'b0;
         end
         if (state_q == ST_IDLE && ea_valid) begin
            op_act_q    <= dec_act; // see [RL2] see [RL16]
            op_kind_q   <= dec_kind;
            op_place_q  <= dec_place;
            tlb_req_q   <= 1'b1;
            tlb_vaddr_q <= ea;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Cache request port.

   always @(posedge clk) begin
      if (!rst_n) begin
         cache_req_q      <= 1'b0;
         cache_addr_q     <= {AW{1'b0}};
         cache_kind_q     <= `PFH_KIND_LOAD;
         cache_place_q    <= `PFH_PLACE_NORMAL;
         cache_attr_q     <= `PFH_ATTR_UNCACHED;
         cache_coherent_q <= 1'b0;
      end else begin
         if (state_q == ST_LOOK && state_d == ST_ISSUE) begin
            cache_req_q      <= 1'b1;
            // Block aligned request that still holds the address.
            cache_addr_q     <= {tlb_vaddr_q[AW-1:BLOCK_BITS], {BLOCK_BITS{1'b0}}}; // see [RL9]
            cache_kind_q     <= op_kind_q; // see [RL12] see [RL14] see [RL5]
            cache_place_q    <= op_place_q; // see [RL13]
            cache_attr_q     <= cache_coherence_attribute; // see [RL8]
            cache_coherent_q <= is_coherent(cache_coherence_attribute); // see [RL10]
         end else if (state_q == ST_ISSUE && cache_ready) begin
            cache_req_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Completion, drop, error report and barrier handshake.

   always @(posedge clk) begin
      if (!rst_n) begin
         done_q        <= 1'b0;
         dropped_q     <= 1'b0;
         err_report_q  <= 1'b0;
         barrier_ack_q <= 1'b0;
      end else begin
         done_q       <= 1'b0;
         dropped_q    <= 1'b0;
         err_report_q <= 1'b0;
         if (state_q == ST_LOOK && state_d == ST_IDLE) begin
            done_q    <= 1'b1;
            // No exception leaves here: faults and uncached just vanish.
            dropped_q <= 1'b1; // see [RL4] see [RL7]
         end
         if (state_q == ST_WAIT && cache_done) begin
            done_q       <= 1'b1;
            err_report_q <= cache_err && (ERR_REPORT != 0); // see [RL6]
         end
         // A barrier is granted only when nothing from a prefetch is in flight.
         barrier_ack_q <= barrier_req && (state_q == ST_IDLE) && !ea_valid; // see [RL11]
      end
   end

endmodule
`default_nettype wire

// *** dv/pfh_unit_chk_sva.sv ***
/* Port checker for the prefetch hint unit, bound to its top module.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module pfh_unit_chk #(
   parameter AW         = 32,
   parameter BLOCK_BITS = 5,
   parameter PREP_STORE = 0,
   parameter ERR_REPORT = 0
) (
   input wire logic          clk,
   input wire logic          rst_n,
   input wire logic          tlb_req_q,
   input wire logic [AW-1:0] tlb_vaddr_q,
   input wire logic          tlb_fault,
   input wire logic [2:0]    cache_coherence_attribute,
   input wire logic          barrier_req,
   input wire logic          barrier_ack_q,
   input wire logic          cache_ready,
   input wire logic          cache_req_q,
   input wire logic [AW-1:0] cache_addr_q,
   input wire logic [2:0]    cache_kind_q,
   input wire logic [2:0]    cache_attr_q,
   input wire logic          cache_coherent_q,
   input wire logic          done_q,
   input wire logic          dropped_q,
   input wire logic          err_report_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_looked;
      tlb_req_q ##1 cache_req_q;
   endsequence
   sequence s_blocked;
      tlb_req_q && (tlb_fault || barrier_req);
   endsequence
   ////////////////////////////////////////
   hold_req_a: assert property (
      cache_req_q && !cache_ready |=> cache_req_q && $stable({cache_addr_q, cache_kind_q}))
      else $error("Request changed before the cache took it.");
   uncached_quiet_a: assert property (
      cache_req_q |-> cache_addr_q[31:29] != 3'h5 && cache_attr_q != 3'h2 && cache_attr_q != 3'h7)
      else $error("Request issued for an uncached address.");
   coherent_map_a: assert property (
      cache_req_q |-> cache_coherent_q == (cache_attr_q == 3'h4 || cache_attr_q == 3'h5))
      else $error("Coherent flag does not match the attribute.");
   block_addr_a: assert property (
      cache_req_q |-> (cache_addr_q >> BLOCK_BITS) == (tlb_vaddr_q >> BLOCK_BITS)
                      && cache_addr_q[BLOCK_BITS-1:0] == '0)
      else $error("Request block does not hold the effective address.");
   attr_follow_a: assert property (
      s_looked |-> cache_attr_q == $past(cache_coherence_attribute))
      else $error("Request attribute differs from the translated one.");
   no_prep_a: assert property (
      cache_req_q && PREP_STORE == 0 |-> cache_kind_q != 3'h3)
      else $error("Prepare-store request issued while disabled.");
   err_quiet_a: assert property (
      err_report_q |-> done_q && ERR_REPORT != 0)
      else $error("Error reported while reporting is off.");
   fault_silent_a: assert property (
      s_blocked |=> (dropped_q && !cache_req_q) ##1 (!cache_req_q)[*2])
      else $error("Request issued for a faulting or barred prefetch.");
   barrier_hold_a: assert property (
      barrier_ack_q |-> !cache_req_q && $past(barrier_req))
      else $error("Barrier granted while a request is out.");
   answer_bound_a: assert property (
      tlb_req_q |-> ##[1:3] (cache_req_q || done_q))
      else $error("Prefetch stalled after translation.");
   drop_only_a: assert property (
      dropped_q |-> done_q && !cache_req_q)
      else $error("Drop flagged without completion.");
endmodule
bind pfh_prefetch_unit pfh_unit_chk #(.AW(AW), .BLOCK_BITS(BLOCK_BITS),
   .PREP_STORE(PREP_STORE), .ERR_REPORT(ERR_REPORT)) u_chk (.clk, .rst_n, .tlb_req_q,
   .tlb_vaddr_q, .tlb_fault, .cache_coherence_attribute, .barrier_req, .barrier_ack_q,
   .cache_ready, .cache_req_q, .cache_addr_q, .cache_kind_q, .cache_attr_q,
   .cache_coherent_q, .done_q, .dropped_q, .err_report_q);
`default_nettype wire

// *** dv/pfh_cache_model.sv ***
/* Cache side model: takes one request, answers fast or slow.
   Assumes the unit drops its request the cycle after ready. */
`timescale 1ns/1ps
`default_nettype none
module pfh_cache_model (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic req,
   input  wire logic slow,
   input  wire logic err,
   output var  logic ready,
   output var  logic done,
   output wire logic done_err
);
   logic [3:0] cnt_q;
   logic       busy_q;
   assign done_err = done & err;
   always @(posedge clk) begin
      ready <= 1'b0;
      done <= 1'b0;
      if (!rst_n) begin
         busy_q <= 1'b0;
         cnt_q <= 4'h0;
      end else if (busy_q) begin
         cnt_q <= cnt_q - 4'h1;
         if (cnt_q == 4'h0) begin
            busy_q <= 1'b0;
            done <= 1'b1;
         end
      end else if (req && !ready) begin
         if (cnt_q == 4'h0) begin
            ready <= 1'b1;
            busy_q <= 1'b1;
            cnt_q <= slow ? 4'h6 : 4'h0;
         end else
            cnt_q <= cnt_q - 4'h1;
      end else
         cnt_q <= slow ? 4'h3 : 4'h0;
   end
endmodule
`default_nettype wire

// *** dv/test_prefetch_hint_unit.sv ***
/* Self-checking bench for the prefetch hint unit.
   Assumes the checker is bound and the cache model stands opposite. */
`timescale 1ns/1ps
`default_nettype none
module test_prefetch_hint_unit;
   logic        clk = 1'b0, rst_n = 1'b0, cache_warm_hint_op = 1'b0, tlb_fault = 1'b0;
   logic        barrier_req = 1'b0, slow = 1'b0, bad = 1'b0;
   logic [4:0]  hint = 5'h00;
   logic [31:0] int_register_file = 32'h0, rs = 32'h0000B268;
   logic [15:0] offset = 16'h0;
   logic [2:0]  cache_coherence_attribute = 3'h0, cache_kind_q, cache_attr_q, k_s, at_s;
   logic [1:0]  cache_place_q, p_s;
   logic [31:0] tlb_vaddr_q, cache_addr_q, va_s, a_s;
   logic        tlb_req_q, barrier_ack_q, cache_req_q, cache_coherent_q, done_q, c_s;
   logic        dropped_q, err_report_q, cache_ready, cache_done, cache_err;
   int          errors = 0, n_checks = 0, n_tlb = 0, n_req = 0;
   always #20 clk = ~clk;
   pfh_prefetch_unit #(.BLOCK_BITS(5), .PREP_STORE(0), .ERR_REPORT(0)) uut (.clk, .rst_n,
      .cache_warm_hint_op, .hint, .int_register_file, .offset, .tlb_req_q, .tlb_vaddr_q,
      .tlb_fault, .cache_coherence_attribute, .cache_ready, .cache_done, .cache_err,
      .barrier_req, .barrier_ack_q, .cache_req_q, .cache_addr_q, .cache_kind_q,
      .cache_place_q, .cache_attr_q, .cache_coherent_q, .done_q, .dropped_q, .err_report_q);
   pfh_cache_model u_mem (.clk, .rst_n, .req(cache_req_q), .slow, .err(bad),
      .ready(cache_ready), .done(cache_done), .done_err(cache_err));
   always @(posedge clk) begin
      if (tlb_req_q) begin
         n_tlb++;
         va_s = tlb_vaddr_q;
      end
      if (cache_req_q && cache_ready) begin
         n_req++;
         {a_s, k_s, p_s, at_s, c_s} = {cache_addr_q, cache_kind_q, cache_place_q,
                                        cache_attr_q, cache_coherent_q};
      end
   end
   ////////////////////////////////////////
   function automatic logic [31:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction
   function automatic logic go(input logic [4:0] h, input logic [31:0] ea,
                               input logic [2:0] at, input logic f, b);
      return !f && !b && ea[31:29] != 3'h5 && at != 3'h2 && at != 3'h7
             && (h <= 5'h01 || (h >= 5'h04 && h <= 5'h07) || h == 5'h19);
   endfunction
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("checks=%0d errors=%0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic do_op(input logic [4:0] h, input logic [31:0] b, input logic [15:0] o,
                        input logic [2:0] at, input logic f, br, dbl);
      logic [31:0] ea;
      logic        e;
      int          t0, r0, w;
      ea = b + {{16{o[15]}}, o};
      e = go(h, ea, at, f, br);
      t0 = n_tlb;
      r0 = n_req;
      w = 0;
      @(negedge clk);
      {hint, int_register_file, offset, cache_coherence_attribute} = {h, b, o, at};
      {tlb_fault, barrier_req, cache_warm_hint_op} = {f, br, 1'b1};
      @(negedge clk);
      cache_warm_hint_op = dbl;
      @(negedge clk);
      cache_warm_hint_op = 1'b0;
      while (done_q !== 1'b1 && w < 60) begin
         @(negedge clk);
         w++;
      end
      chk(w < 60, 1);
      chk(dropped_q, !e);
      chk(err_report_q, 0);
      chk(va_s, ea);
      if (e) begin
         chk({a_s, at_s}, {ea & 32'hFFFFFFE0, at});
         chk(c_s, at == 3'h4 || at == 3'h5);
         chk(k_s, h == 5'h19 ? 3'h2 : {2'h0, h[0]});
         chk(p_s, h[4:1] == 4'h2 ? 2'h1 : h[4:1] == 4'h3 ? 2'h2 : 2'h0);
      end
      repeat (3) @(negedge clk);
      chk(n_req - r0, e);
      chk(n_tlb - t0, 1);
      chk(barrier_ack_q, br);
      {tlb_fault, barrier_req} = 2'h0;
   endtask
   task automatic rst6();
      rst_n = 1'b0;
      repeat (6) @(negedge clk);
      chk({cache_req_q, done_q, tlb_req_q, cache_attr_q}, 6'h02);
      rst_n = 1'b1;
   endtask
   ////////////////////////////////////////
   initial begin
      logic [31:0] r;
      rst6();
      for (int p = 0; p < 3; p++)
         for (int h = 0; h < 32; h++) begin
            r = rnd();
            {slow, bad} = r[1:0];
            do_op(h[4:0], rnd(), r[31:16], r[4:2], r[7:5] == 3'h0, r[10:8] == 3'h0, 1'b0);
         end
      rst6();
      do_op(5'h00, 32'h00001000, 16'h8000, 3'h4, 1'b0, 1'b0, 1'b1);
      do_op(5'h19, 32'hFFFFFFF0, 16'h7FFF, 3'h3, 1'b0, 1'b0, 1'b0);
      do_op(5'h01, 32'hA0000040, 16'h0000, 3'h3, 1'b0, 1'b0, 1'b0);
      do_op(5'h06, 32'h00000100, 16'h0010, 3'h5, 1'b1, 1'b0, 1'b0);
      do_op(5'h1F, 32'h00000200, 16'h0004, 3'h3, 1'b0, 1'b0, 1'b0);
      do_op(5'h04, 32'h00000300, 16'hFFFC, 3'h4, 1'b0, 1'b1, 1'b1);
      close_out();
   end
   initial begin
      #(20000 * 40);
      errors++;
      close_out();
   end
endmodule
`default_nettype wire
